// ---- parallel_io_output_filter_regs.sv ----
// Output enable, glitch filter and output data registers of one 32-line port.
// Assumes an APB3 master on sys_clk and output_write_status from a sibling block.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module parallel_io_output_filter_regs (
  input  wire logic        sys_clk,           // Peripheral clock, 125 MHz
  input  wire logic        resetn,            // Synchronous reset, low active
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB access phase
  input  wire logic        pwrite,            // APB direction, 1 = write
  input  wire logic [11:0] paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic      [31:0] prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error on unmapped access
  input  wire logic [31:0] outputWriteStatus, // Lines open to direct writes
  input  wire logic [31:0] padIn,             // Pad input levels
  output logic      [31:0] padOut,            // Pad output levels
  output logic      [31:0] padOutEn           // Pad driver enables
);

  localparam int W = pio_regs_pkg::LINE_COUNT;

  logic [W-1:0]  outEnable_q;
  logic [W-1:0]  outEnable_d;
  logic [W-1:0]  filterEnable_q;
  logic [W-1:0]  filterEnable_d;
  logic [W-1:0]  outValue_q;
  logic [W-1:0]  outValue_d;
  logic [31:0]   prdata_q;
  logic [31:0]   readMux;
  logic [W-1:0]  pinLevel;

  // Bus phase decode
  wire setupPhase  = psel & ~penable;
  wire accessPhase = psel & penable;
  wire writeAccess = accessPhase & pwrite;

  // Address decode
  wire hitOutEn     = (paddr == pio_regs_pkg::OFS_OUTPUT_ENABLE);
  wire hitOutDis    = (paddr == pio_regs_pkg::OFS_OUTPUT_DISABLE);
  wire hitOutStat   = (paddr == pio_regs_pkg::OFS_OUTPUT_ENABLE_STATUS);
  wire hitFiltEn    = (paddr == pio_regs_pkg::OFS_FILTER_ENABLE);
  wire hitFiltDis   = (paddr == pio_regs_pkg::OFS_FILTER_DISABLE);
  wire hitFiltStat  = (paddr == pio_regs_pkg::OFS_FILTER_STATUS);
  wire hitValSet    = (paddr == pio_regs_pkg::OFS_VALUE_SET);
  wire hitValClr    = (paddr == pio_regs_pkg::OFS_VALUE_CLEAR);
  wire hitValStat   = (paddr == pio_regs_pkg::OFS_VALUE_STATUS);
  wire hitPinStat   = (paddr == pio_regs_pkg::OFS_PIN_LEVEL_STATUS);
  wire anyHit       = hitOutEn | hitOutDis | hitOutStat | hitFiltEn | hitFiltDis
                    | hitFiltStat | hitValSet | hitValClr | hitValStat | hitPinStat;

  // Write strobes, one per writable register
  wire wrOutEn   = writeAccess & hitOutEn;
  wire wrOutDis  = writeAccess & hitOutDis;
  wire wrFiltEn  = writeAccess & hitFiltEn;
  wire wrFiltDis = writeAccess & hitFiltDis;
  wire wrValSet  = writeAccess & hitValSet;
  wire wrValClr  = writeAccess & hitValClr;
  wire wrValStat = writeAccess & hitValStat;

  // Per-line masks; zero bits of a set or clear word leave state alone
  wire [W-1:0] outEnSet   = wrOutEn   ? pwdata : '0;
  wire [W-1:0] outEnClr   = wrOutDis  ? pwdata : '0;
  wire [W-1:0] filtSet    = wrFiltEn  ? pwdata : '0;
  wire [W-1:0] filtClr    = wrFiltDis ? pwdata : '0;
  wire [W-1:0] valSet     = wrValSet  ? pwdata : '0;
  wire [W-1:0] valClr     = wrValClr  ? pwdata : '0;
  wire [W-1:0] directMask = wrValStat ? outputWriteStatus : '0;

  // Next state; only one register is written per access, so no set/clear race
  assign outEnable_d    = (outEnable_q | outEnSet) & ~outEnClr;
  assign filterEnable_d = (filterEnable_q | filtSet) & ~filtClr;
  assign outValue_d     = ((((outValue_q & ~directMask) | (pwdata & directMask))
                          | valSet) & ~valClr);

  // Control state, updated at the access edge
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      outEnable_q    <= pio_regs_pkg::RST_OUTPUT_ENABLE;
      filterEnable_q <= pio_regs_pkg::RST_FILTER_ENABLE;
      outValue_q     <= pio_regs_pkg::RST_OUTPUT_VALUE;
    end else begin
      outEnable_q    <= outEnable_d;
      filterEnable_q <= filterEnable_d;
      outValue_q     <= outValue_d;
    end
  end

  // Pin path; filter enables steer the capture per line
  pin_level_filter #(
    .WIDTH    (W)
  ) u_pin_level (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .lineIn   (padIn),
    .filterEn (filterEnable_q),
    .levelOut (pinLevel)
  );

  // Read selection; write-only registers read as zero
  always_comb begin
    readMux = pio_regs_pkg::READ_ZERO;
    if (hitOutStat) begin
      readMux = outEnable_q;
    end else if (hitFiltStat) begin
      readMux = filterEnable_q;
    end else if (hitValStat) begin
      readMux = outValue_q;
    end else if (hitPinStat) begin
      readMux = pinLevel;
    end
  end

  // Read data is caught in setup so prdata comes from a flop with no wait state
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prdata_q <= pio_regs_pkg::READ_ZERO;
    end else if (setupPhase && !pwrite) begin
      prdata_q <= readMux;
    end
  end

  // Bus answers: always ready, error only for unmapped addresses
  assign prdata   = prdata_q;
  assign pready   = 1'b1;
  assign pslverr  = accessPhase & ~anyHit;

  // Pad drive straight from the control flops
  assign padOut   = outValue_q;
  assign padOutEn = outEnable_q;

  // ---------------- Assertions ----------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence readSetup(logic [11:0] addr);
    psel && !penable && !pwrite && (paddr == addr);
  endsequence

  sequence readAccess;
    psel && penable && !pwrite;
  endsequence

  a_oe_set_bits: assert property (
    wrOutEn |=> ((outEnable_q & $past(pwdata)) == $past(pwdata)))
    else $error("Output enable write did not turn lines on");

  a_oe_clear_bits: assert property (
    wrOutDis |=> ((outEnable_q & $past(pwdata)) == '0) &&
                 ((outEnable_q & ~$past(pwdata)) == ($past(outEnable_q) & ~$past(pwdata))))
    else $error("Output disable write wrong on some line");

  a_osr_readback: assert property (
    readSetup(pio_regs_pkg::OFS_OUTPUT_ENABLE_STATUS) ##1 readAccess
      |-> (prdata == $past(outEnable_q)))
    else $error("Output status read does not match drivers");

  a_filt_set_bits: assert property (
    wrFiltEn |=> ((filterEnable_q & $past(pwdata)) == $past(pwdata)) &&
                 ((filterEnable_q & ~$past(pwdata)) == ($past(filterEnable_q) & ~$past(pwdata))))
    else $error("Filter enable write wrong on some line");

  a_filt_clear_bits: assert property (
    wrFiltDis |=> ((filterEnable_q & $past(pwdata)) == '0))
    else $error("Filter disable write did not turn filters off");

  a_fsr_readback: assert property (
    readSetup(pio_regs_pkg::OFS_FILTER_STATUS) ##1 readAccess
      |-> (prdata == $past(filterEnable_q)))
    else $error("Filter status read does not match filters");

  a_value_set_bits: assert property (
    wrValSet |=> ((outValue_q & $past(pwdata)) == $past(pwdata)) &&
                 ((padOut & ~$past(pwdata)) == ($past(outValue_q) & ~$past(pwdata))))
    else $error("Value set write wrong on some line");

  a_value_clear_bits: assert property (
    wrValClr |=> ((padOut & $past(pwdata)) == '0))
    else $error("Value clear write did not drive lines low");

  a_value_gated: assert property (
    wrValStat |=> (((outValue_q ^ $past(outValue_q)) & ~$past(outputWriteStatus)) == '0) &&
                  ((outValue_q & $past(outputWriteStatus))
                    == ($past(pwdata) & $past(outputWriteStatus))))
    else $error("Direct value write broke the write gating");

  a_pin_settles: assert property (
    (!$changed(padIn) && (filterEnable_q == '0))[*6] |-> (pinLevel == padIn))
    else $error("Pin level did not follow a steady pad");

  // Output write status lives in a sibling block, so its offset is unmapped here
  a_unmapped_err: assert property (
    (accessPhase && (paddr == pio_regs_pkg::OFS_OUTPUT_WRITE_STATUS)) |-> pslverr && pready)
    else $error("Unmapped address not flagged");

  a_odsr_readback: assert property (
    readSetup(pio_regs_pkg::OFS_VALUE_STATUS) ##1 readAccess
      |-> (prdata == $past(outValue_q)))
    else $error("Value status read does not match drive values");

  a_pdsr_readback: assert property (
    readSetup(pio_regs_pkg::OFS_PIN_LEVEL_STATUS) ##1 readAccess
      |-> (prdata == $past(pinLevel)))
    else $error("Pin status read does not match captured levels");

  a_wo_reads_zero: assert property (
    readSetup(pio_regs_pkg::OFS_OUTPUT_ENABLE) ##1 readAccess
      |-> (prdata == pio_regs_pkg::READ_ZERO))
    else $error("Write-only register did not read as zero");

endmodule : parallel_io_output_filter_regs

`default_nettype wire

// ---- pio_regs_pkg.sv ----
// Constants for the parallel I/O output and glitch filter register slice.
// Assumes a 32-bit APB3 bus with byte addresses and one word per register.
//
// What this block does
// - Writing 1 to output_enable turns that line's driver on; 0 bits do nothing.
// - Writing 1 to output_disable turns that line's driver off; 0 bits do nothing.
// - output_enable_status reads 1 for driven lines, 0 for pure inputs.
// - Writing 1 to glitch_filter_enable turns that line's filter on; 0 bits ignored.
// - Writing 1 to glitch_filter_disable turns that line's filter off; 0 bits ignored.
// - glitch_filter_status reads 1 where the filter is on, else 0.
// - Writing 1 to output_value_set makes the stored drive value one.
// - Writing 1 to output_value_clear makes the stored drive value zero.
// - output_value_status reads the stored drive value per line.
// - output_value_status may be read-only or writable, writes update drive values directly.
// - pin_level_status reads the level actually present on each line.
// - All registers are 32 bits, bit n belongs to line n.
// - output_value_status writes only affect lines enabled in output_write_status.
// - Pin levels sample only while the clock runs, else hold last capture.

package pio_regs_pkg;

  localparam int LINE_COUNT = 32;
  localparam int APB_ADDR_W = 12;

  // Register byte offsets
  localparam logic [APB_ADDR_W-1:0] OFS_OUTPUT_ENABLE        = 12'h010;
  localparam logic [APB_ADDR_W-1:0] OFS_OUTPUT_DISABLE       = 12'h014;
  localparam logic [APB_ADDR_W-1:0] OFS_OUTPUT_ENABLE_STATUS = 12'h018;
  localparam logic [APB_ADDR_W-1:0] OFS_FILTER_ENABLE        = 12'h020;
  localparam logic [APB_ADDR_W-1:0] OFS_FILTER_DISABLE       = 12'h024;
  localparam logic [APB_ADDR_W-1:0] OFS_FILTER_STATUS        = 12'h028;
  localparam logic [APB_ADDR_W-1:0] OFS_VALUE_SET            = 12'h030;
  localparam logic [APB_ADDR_W-1:0] OFS_VALUE_CLEAR          = 12'h034;
  localparam logic [APB_ADDR_W-1:0] OFS_VALUE_STATUS         = 12'h038;
  localparam logic [APB_ADDR_W-1:0] OFS_PIN_LEVEL_STATUS     = 12'h03C;
  localparam logic [APB_ADDR_W-1:0] OFS_OUTPUT_WRITE_STATUS  = 12'h0A8;

  // Reset values
  localparam logic [LINE_COUNT-1:0] RST_OUTPUT_ENABLE = 32'h0000_0000;
  localparam logic [LINE_COUNT-1:0] RST_FILTER_ENABLE = 32'h0000_0000;
  localparam logic [LINE_COUNT-1:0] RST_OUTPUT_VALUE  = 32'h0000_0000;
  localparam logic [LINE_COUNT-1:0] RST_PIN_LEVEL     = 32'h0000_0000;
  localparam logic [31:0]           READ_ZERO         = 32'h0000_0000;

  // Pin path timing in clock cycles
  localparam int SYNC_STAGES   = 3;
  localparam int FILTER_EXTRA  = 1;
  localparam int PIN_LATENCY   = SYNC_STAGES + 1;

endpackage : pio_regs_pkg

// ---- pin_level_filter.sv ----
// Pin synchroniser and per-line glitch filter feeding the pin level register.
// Assumes pad inputs are asynchronous to sys_clk; runs on sys_clk only.
`timescale 1ns/1ps
`default_nettype none

module pin_level_filter #(
  parameter int WIDTH = 32
) (
  input  wire logic             sys_clk,   // Peripheral clock
  input  wire logic             resetn,    // Synchronous reset, low active
  input  wire logic [WIDTH-1:0] lineIn,    // Raw pad levels
  input  wire logic [WIDTH-1:0] filterEn,  // Per-line filter on
  output logic      [WIDTH-1:0] levelOut   // Captured pin levels
);

  logic [WIDTH-1:0] syncA_q;
  logic [WIDTH-1:0] syncB_q;
  logic [WIDTH-1:0] syncC_q;
  logic [WIDTH-1:0] syncD_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] level_d;
  wire  [WIDTH-1:0] agreeTwo;
  wire  [WIDTH-1:0] agreeThree;
  wire  [WIDTH-1:0] takeNew;

  // Three-stage capture plus one filter stage; syncA feeds only syncB
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      syncA_q <= '0;
      syncB_q <= '0;
      syncC_q <= '0;
      syncD_q <= '0;
    end else begin
      syncA_q <= lineIn;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
      syncD_q <= syncC_q;
    end
  end

  // Unfiltered: second and third stage agree; filtered: one more sample must agree
  assign agreeTwo   = ~(syncB_q ^ syncC_q);
  assign agreeThree = agreeTwo & ~(syncC_q ^ syncD_q);
  assign takeNew    = (filterEn & agreeThree) | (~filterEn & agreeTwo);
  assign level_d    = (syncB_q & takeNew) | (level_q & ~takeNew);

  // Holds the last capture whenever the clock stops
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      level_q <= WIDTH'(pio_regs_pkg::RST_PIN_LEVEL);
    end else begin
      level_q <= level_d;
    end
  end

  assign levelOut = level_q;

endmodule : pin_level_filter

`default_nettype wire

// ---- pad_model.sv ----
// Pad ring model: outside drivers meet the block's output drivers.
// Assumes the bench sets the far-end levels; the block wins any contention.
`timescale 1ns/1ps
`default_nettype none

module pad_model (
  input  wire logic [31:0] extLevel,  // Levels driven from outside
  input  wire logic [31:0] padOut,    // Block drive values
  input  wire logic [31:0] padOutEn,  // Block driver enables
  output logic      [31:0] lineLevel  // Resolved wire levels
);
  // Driven lines follow the block, pure inputs follow the outside driver
  assign lineLevel = (padOut & padOutEn) | (extLevel & ~padOutEn);
endmodule : pad_model

`default_nettype wire

// ---- parallel_io_output_filter_regs_tb_top.sv ----
// Register and pin bench for the output and glitch filter register slice.
// Assumes a zero-wait APB slave and pad_model on the pad side.
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failCount++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end

module parallel_io_output_filter_regs_tb_top;
  logic        sys_clk           = 1'b0;
  logic        resetn            = 1'b0;
  logic        psel              = 1'b0;
  logic        penable           = 1'b0;
  logic        pwrite            = 1'b0;
  logic [11:0] paddr             = 12'h000;
  logic [31:0] pwdata            = 32'h0000_0000;
  logic [31:0] outputWriteStatus = 32'h0000_0000;
  logic [31:0] extLevel          = 32'h0000_0000;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [31:0] padOut;
  wire  [31:0] padOutEn;
  wire  [31:0] lineLevel;
  logic [31:0] rdData;
  logic        errBit;
  int          failCount = 0;
  int          checked   = 0;
  logic [11:0] ofsE[3] = '{12'h010, 12'h020, 12'h030};
  logic [11:0] ofsD[3] = '{12'h014, 12'h024, 12'h034};
  logic [11:0] ofsS[3] = '{12'h018, 12'h028, 12'h038};

  // Free-running 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  parallel_io_output_filter_regs parallel_io_output_filter_regs_i (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .outputWriteStatus(outputWriteStatus),
    .padIn(lineLevel), .padOut(padOut), .padOutEn(padOutEn));

  pad_model pad_model_i (
    .extLevel(extLevel), .padOut(padOut), .padOutEn(padOutEn), .lineLevel(lineLevel));

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // One APB transfer; a slave that never answers ends the run
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failCount++;
      final_report();
    end
    rdData = prdata;
    errBit = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rdData, e)
    `CHK(errBit, 1'b0)
  endtask : rd

  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 3; i++) begin
      rd(ofsS[i], 32'h0000_0000);
      rd(ofsE[i], 32'h0000_0000);
      rd(ofsD[i], 32'h0000_0000);
    end
    $display("Test reset values done");
    // Same set/clear pattern for drivers, filters and drive values
    for (int i = 0; i < 3; i++) begin
      wr(ofsE[i], 32'hA5A5_0F0F);
      rd(ofsS[i], 32'hA5A5_0F0F);
      wr(ofsE[i], 32'h0000_0000);
      wr(ofsD[i], 32'h0000_0000);
      rd(ofsS[i], 32'hA5A5_0F0F);
      wr(ofsD[i], 32'h8001_0F00);
      rd(ofsS[i], 32'h25A4_000F);
      wr(ofsE[i], 32'h8000_0001);
      rd(ofsS[i], 32'hA5A4_000F);
    end
    `CHK(padOutEn, 32'hA5A4_000F)
    `CHK(padOut, 32'hA5A4_000F)
    for (int i = 0; i < 2; i++) begin
      wr(ofsS[i], 32'h0000_0000);
      rd(ofsS[i], 32'hA5A4_000F);
    end
    $display("Test set and clear done");
    // Direct writes reach only the lines opened by output_write_status
    outputWriteStatus <= 32'h0000_FFFF;
    wr(ofsS[2], 32'h1234_5678);
    rd(ofsS[2], 32'hA5A4_5678);
    `CHK(padOut, 32'hA5A4_5678)
    apb(1'b1, 12'h0A8, 32'hFFFF_FFFF);
    `CHK(errBit, 1'b1)
    apb(1'b0, 12'h040, 32'h0000_0000);
    `CHK(errBit, 1'b1)
    rd(ofsS[2], 32'hA5A4_5678);
    $display("Test direct write done");
    // Pin levels mix driven lines and outside levels
    extLevel <= 32'h0F0F_F0F0;
    repeat (8) @(posedge sys_clk);
    rd(12'h03C, (32'hA5A4_5678 & 32'hA5A4_000F) | (32'h0F0F_F0F0 & 32'h5A5B_FFF0));
    // Two-sample pulse: unfiltered line 8 shows it briefly, filtered line 1 never does
    wr(ofsD[0], 32'h0000_0002);
    extLevel <= 32'h0F0F_F1F2;
    repeat (2) @(posedge sys_clk);
    extLevel <= 32'h0F0F_F0F0;
    repeat (2) @(posedge sys_clk);
    rd(12'h03C, (32'hA5A4_5678 & 32'hA5A4_000D) | (32'h0F0F_F1F0 & 32'h5A5B_FFF2));
    repeat (8) @(posedge sys_clk);
    rd(12'h03C, (32'hA5A4_5678 & 32'hA5A4_000D) | (32'h0F0F_F0F0 & 32'h5A5B_FFF2));
    extLevel <= 32'h0F0F_F0F2;
    repeat (8) @(posedge sys_clk);
    rd(12'h03C, (32'hA5A4_5678 & 32'hA5A4_000D) | (32'h0F0F_F0F2 & 32'h5A5B_FFF2));
    $display("Test pin levels done");
    final_report();
  end
endmodule : parallel_io_output_filter_regs_tb_top

`default_nettype wire
